// ===== rtl/e1_alarm_params.svh
// Purpose: Offsets, bit positions, reset values and counts for the
//          E1 alarm, event flag and interrupt mask block.
// Assumes: Counts of line bits are taken at 2.048 Mbit/s.
// Notes:   Included by its bare name.
`ifndef E1_ALARM_PARAMS_SVH
`define E1_ALARM_PARAMS_SVH

// Register offsets on the parallel port.
`define REG_RX_ALARM_STATUS 8'h06
`define REG_EVENT_STATUS    8'h07
`define REG_RX_ALARM_MASK   8'h16
`define REG_EVENT_MASK      8'h17
`define REG_IRQ_SUMMARY     8'h18

// Reset values.
`define STATUS_RESET 8'h00
`define MASK_RESET   8'h00
`define RDATA_RESET  8'h00

// Receive alarm status bit positions.
`define B_SIG_ALL_ONES  7
`define B_DISTANT_MF    6
`define B_SIG_ALL_ZEROS 5
`define B_RX_SLIP       4
`define B_UNFRAMED_ONES 3
`define B_FAR_END       2
`define B_CARRIER_LOSS  1
`define B_SYNC_LOSS     0

// Event status bit positions.
`define B_CAS_MF_RX   7
`define B_RX_ALIGN    6
`define B_TX_MF       5
`define B_TIMER_TICK  4
`define B_TX_ALIGN    3
`define B_TX_CLK_LOSS 2
`define B_CRC_MF_RX   1
`define B_TX_SLIP     0

// Framing positions and counts, in line bits or frames.
`define TS_SIGNALING  5'd16
`define TS_ALIGN      5'd0
`define MF_FIRST      4'd0
`define BIT6_INDEX    3'd5
`define BIT3_INDEX    3'd2
`define ZERO_LIMIT    2'd3
`define RUN_LIMIT     2'd3
`define UAO_SPAN_LAST 9'd511
`define CL_ZERO_RUN   8'd255
`define CL_WIN_LAST   8'd254
`define CL_ONES_MIN   6'd32
`define CHANNEL_BITS  4'd8
`define TICK_BITS_1S  2048000
`define TICK_BITS_62MS 128000
`define MF_FRAME_LAST 4'd15

`endif

// ===== rtl/e1_alarm_pkg.sv
// Purpose: Types shared by the alarm block and its status latches.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds types only.
package e1_alarm_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [1:0] sat_t;
endpackage

// ===== rtl/status_latch_if.sv
// Purpose: Carries one latched status byte and its mask between modules.
// Assumes: One clock shared by both ends.
// Notes:   The block drives events and port strobes, the latch answers.
`timescale 1ns/100ps
interface status_latch_if;
	import e1_alarm_pkg::*;
	byte_t set_ev;
	logic  wr_stat;
	logic  wr_mask;
	byte_t wdata;
	byte_t rd_val;
	byte_t mask;
	logic  pending;
	modport ctrl (
		output set_ev,
		output wr_stat,
		output wr_mask,
		output wdata,
		input  rd_val,
		input  mask,
		input  pending
	);
	modport latch (
		input  set_ev,
		input  wr_stat,
		input  wr_mask,
		input  wdata,
		output rd_val,
		output mask,
		output pending
	);
endinterface

// ===== rtl/status_latch.sv
// Purpose: One latched status byte with read-hold value and mask.
// Assumes: Events are levels or pulses synchronous to clk.
// Notes:   A set in the clearing cycle wins over the clear.
`timescale 1ns/100ps
`include "e1_alarm_params.svh"
module status_latch (
	input wire logic          clk,
	input wire logic          rst,
	status_latch_if.latch     lif
);
	import e1_alarm_pkg::*;

	byte_t status;
	byte_t held;
	byte_t mask_q;
	byte_t clr;

	// Bits chosen by a status write are sampled and cleared.
	assign clr = lif.wr_stat ? lif.wdata : 8'h00;

	// Flags stay set until chosen by a write; new events win.
	always_ff @(posedge clk) begin
		if (rst) begin
			status <= `STATUS_RESET;
		end else begin
			status <= (status & ~clr) | lif.set_ev;
		end
	end

	// Chosen bits take the live value, the others hold.
	always_ff @(posedge clk) begin
		if (rst) begin
			held <= `STATUS_RESET;
		end else begin
			held <= (status & clr) | (held & ~clr);
		end
	end

	// Mask register.
	always_ff @(posedge clk) begin
		if (rst) begin
			mask_q <= `MASK_RESET;
		end else if (lif.wr_mask) begin
			mask_q <= lif.wdata;
		end
	end

	// A bit reaches the interrupt only where its mask bit is one.
	assign lif.pending = |(status & mask_q);
	assign lif.rd_val  = held;
	assign lif.mask    = mask_q;
endmodule

// ===== rtl/e1_alarm_status_irq.sv
// Purpose: Receive alarm detection, event flags and interrupt masking
//          for one E1 framer.
// Assumes: Line and framing inputs are synchronous to clk and qualified
//          by rx_bit_en, one pulse per received line bit.
// Notes:   Other framers feed their pending bits into the summary.
// Functional notes
// - Signaling all ones: under three zeros.
// - All ones clears at three zeros.
// - Signaling all zeros over one multiframe.
// - All zeros clears on any one.
// - Distant alarm: bit six twice one.
// - Distant alarm clears: bit six twice zero.
// - Unframed ones: under three zeros per 512.
// - Unframed ones clears above two zeros.
// - Remote alarm on three equal bits.
// - Carrier loss after 255 zeros.
// - Carrier loss clears: 32 ones in 255.
// - Sync loss while not synchronized.
// - Elastic store slips set their flags.
// - Receive multiframe flag every multiframe.
// - Align frame flags each align frame.
// - Transmit multiframe flag each boundary.
// - Timer tick each second or 62.5 ms.
// - Transmit clock loss after one channel.
// - CRC multiframe flag, free when disabled.
// - First mask gates first status.
// - Second mask gates second status.
// - Status flags latch until written.
// - Written ones sample and clear bits.
// - Shared interrupt with framer summary register.
`timescale 1ns/100ps
`include "e1_alarm_params.svh"
module e1_alarm_status_irq #(
	parameter int         TICK_SLOW_BITS = `TICK_BITS_1S,
	parameter int         TICK_FAST_BITS = `TICK_BITS_62MS,
	parameter logic [1:0] FRAMER_INDEX   = 2'd0
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic [7:0]    bus_addr,
	input  wire logic          bus_wr,
	input  wire logic          bus_rd,
	input  e1_alarm_pkg::byte_t bus_wdata,
	output e1_alarm_pkg::byte_t bus_rdata,
	input  wire logic          rx_bit_en,
	input  wire logic          rx_pos_rail,
	input  wire logic          rx_neg_rail,
	input  wire logic          rx_frame_start,
	input  wire logic [3:0]    rx_frame_num,
	input  wire logic [4:0]    rx_ts,
	input  wire logic [2:0]    rx_bit_index,
	input  wire logic          rx_in_sync,
	input  wire logic          rx_crc_mf_start,
	input  wire logic          crc4_enable,
	input  wire logic          rx_estore_slip,
	input  wire logic          tx_estore_slip,
	input  wire logic          tx_align_start,
	input  wire logic          tx_mf_start,
	input  wire logic          line_tx_clock,
	input  wire logic          timer_rate_select,
	input  wire logic          clk_loss_pin_enable,
	input  e1_alarm_pkg::byte_t peer_irq_summary,
	output logic [1:0]         framer_pending,
	output logic               tx_clock_loss_pin,
	output logic               int_n
);
	import e1_alarm_pkg::*;

	// Saturating two-bit count, shared by the short counters.
	function automatic sat_t sat3(input sat_t v);
		return (v == 2'd3) ? v : v + 2'd1;
	endfunction

	status_latch_if alarm_if ();
	status_latch_if event_if ();

	byte_t rx_alarm;
	byte_t events;
	byte_t own_bits;
	byte_t own_slot;
	byte_t framer_irq_summary;
	byte_t next_rdata;

	logic  line_one;
	logic  ts16_bit;
	logic  mf_start;
	logic  dma_tick;
	logic  nas_tick;
	logic  align_rx;

	sat_t  sao_zeros;
	logic  sig_all_ones_flag;
	logic  saz_seen_one;
	logic  sig_all_zeros_flag;
	logic  dma_prev;
	logic  distant_mf_alarm;

	logic [8:0] uao_span;
	sat_t  uao_zeros;
	sat_t  next_uao_zeros;
	logic  unframed_all_ones;

	sat_t  fea_ones;
	sat_t  fea_zeros;
	logic  far_end_alarm;

	logic [7:0] cl_run;
	logic [7:0] cl_win;
	logic [5:0] cl_ones;
	logic  carrier_loss_flag;

	logic [20:0] tick_cnt;
	logic [20:0] tick_last;
	logic  timer_tick_flag;

	logic  line_tx_clock_prev;
	logic [3:0] chan_cnt;
	logic  tx_clock_loss_flag;

	logic [3:0] free_frames;
	logic  crc_mf_rx_flag;

	logic  sel_alarm;
	logic  sel_event;
	logic  sel_amask;
	logic  sel_emask;
	logic  sel_summary;

	// Receive framing context decoded once per line bit.
	assign line_one = rx_pos_rail | rx_neg_rail;
	assign ts16_bit = rx_bit_en & (rx_ts == `TS_SIGNALING);
	assign mf_start = rx_frame_start & (rx_frame_num == `MF_FIRST);
	assign align_rx = rx_frame_start & ~rx_frame_num[0];
	assign dma_tick = ts16_bit & (rx_frame_num == `MF_FIRST)
		& (rx_bit_index == `BIT6_INDEX);
	assign nas_tick = rx_bit_en & (rx_ts == `TS_ALIGN)
		& rx_frame_num[0] & (rx_bit_index == `BIT3_INDEX);

	// Signaling all ones: count zeros in timeslot 16 per multiframe.
	always_ff @(posedge clk) begin
		if (rst) begin
			sao_zeros <= 2'd0;
			sig_all_ones_flag <= 1'b0;
		end else if (mf_start) begin
			sig_all_ones_flag <= sao_zeros < `ZERO_LIMIT;
			sao_zeros <= 2'd0;
		end else if (ts16_bit & ~line_one) begin
			sao_zeros <= sat3(sao_zeros);
		end
	end

	// Signaling all zeros: any one in timeslot 16 ends the condition.
	always_ff @(posedge clk) begin
		if (rst) begin
			saz_seen_one <= 1'b0;
			sig_all_zeros_flag <= 1'b0;
		end else if (mf_start) begin
			sig_all_zeros_flag <= ~saz_seen_one;
			saz_seen_one <= 1'b0;
		end else if (ts16_bit & line_one) begin
			saz_seen_one <= 1'b1;
		end
	end

	// Distant multiframe alarm: two equal bit six samples change state.
	always_ff @(posedge clk) begin
		if (rst) begin
			dma_prev <= 1'b0;
			distant_mf_alarm <= 1'b0;
		end else if (dma_tick) begin
			dma_prev <= line_one;
			if (line_one & dma_prev) begin
				distant_mf_alarm <= 1'b1;
			end else if (~line_one & ~dma_prev) begin
				distant_mf_alarm <= 1'b0;
			end
		end
	end

	// Unframed all ones judged on each 512-bit span.
	assign next_uao_zeros = line_one ? uao_zeros : sat3(uao_zeros);

	always_ff @(posedge clk) begin
		if (rst) begin
			uao_span <= 9'd0;
			uao_zeros <= 2'd0;
			unframed_all_ones <= 1'b0;
		end else if (rx_bit_en) begin
			if (uao_span == `UAO_SPAN_LAST) begin
				// Under three zeros sets, three or more clears.
				unframed_all_ones <= next_uao_zeros < `ZERO_LIMIT;
				uao_span <= 9'd0;
				uao_zeros <= 2'd0;
			end else begin
				uao_span <= uao_span + 9'd1;
				uao_zeros <= next_uao_zeros;
			end
		end
	end

	// Remote alarm: runs of three equal bit three samples.
	always_ff @(posedge clk) begin
		if (rst) begin
			fea_ones <= 2'd0;
			fea_zeros <= 2'd0;
			far_end_alarm <= 1'b0;
		end else if (nas_tick) begin
			if (line_one) begin
				fea_ones <= sat3(fea_ones);
				fea_zeros <= 2'd0;
				if (sat3(fea_ones) == `RUN_LIMIT) begin
					far_end_alarm <= 1'b1;
				end
			end else begin
				fea_zeros <= sat3(fea_zeros);
				fea_ones <= 2'd0;
				if (sat3(fea_zeros) == `RUN_LIMIT) begin
					far_end_alarm <= 1'b0;
				end
			end
		end
	end

	// Carrier loss: zero run sets, 32 ones in a 255-bit window clear.
	always_ff @(posedge clk) begin
		if (rst) begin
			cl_run <= 8'd0;
			cl_win <= 8'd0;
			cl_ones <= 6'd0;
			carrier_loss_flag <= 1'b0;
		end else if (rx_bit_en) begin
			cl_run <= line_one ? 8'd0
				: (cl_run == `CL_ZERO_RUN) ? cl_run : cl_run + 8'd1;
			if (~carrier_loss_flag) begin
				cl_win <= 8'd0;
				cl_ones <= 6'd0;
				if (~line_one & (cl_run == `CL_ZERO_RUN - 8'd1)) begin
					carrier_loss_flag <= 1'b1;
				end
			end else if (cl_win == `CL_WIN_LAST) begin
				cl_win <= 8'd0;
				cl_ones <= 6'd0;
				if ((cl_ones + {5'd0, line_one}) >= `CL_ONES_MIN) begin
					carrier_loss_flag <= 1'b0;
				end
			end else begin
				cl_win <= cl_win + 8'd1;
				if (line_one & (cl_ones != `CL_ONES_MIN)) begin
					cl_ones <= cl_ones + 6'd1;
				end
			end
		end
	end

	// Timer tick counted in received line bits.
	assign tick_last = timer_rate_select ? 21'(TICK_FAST_BITS - 1)
		: 21'(TICK_SLOW_BITS - 1);

	always_ff @(posedge clk) begin
		if (rst) begin
			tick_cnt <= 21'd0;
			timer_tick_flag <= 1'b0;
		end else begin
			timer_tick_flag <= 1'b0;
			if (rx_bit_en) begin
				if (tick_cnt >= tick_last) begin
					tick_cnt <= 21'd0;
					timer_tick_flag <= 1'b1;
				end else begin
					tick_cnt <= tick_cnt + 21'd1;
				end
			end
		end
	end

	// Transmit clock watch: eight receive bits without a toggle.
	always_ff @(posedge clk) begin
		if (rst) begin
			line_tx_clock_prev <= 1'b0;
			chan_cnt <= 4'd0;
			tx_clock_loss_flag <= 1'b0;
			tx_clock_loss_pin <= 1'b0;
		end else begin
			line_tx_clock_prev <= line_tx_clock;
			if (line_tx_clock_prev ^ line_tx_clock) begin
				chan_cnt <= 4'd0;
				tx_clock_loss_flag <= 1'b0;
			end else if (rx_bit_en & (chan_cnt != `CHANNEL_BITS)) begin
				chan_cnt <= chan_cnt + 4'd1;
				tx_clock_loss_flag <= (chan_cnt + 4'd1) == `CHANNEL_BITS;
			end
			tx_clock_loss_pin <= tx_clock_loss_flag & clk_loss_pin_enable;
		end
	end

	// Free multiframe count used while CRC4 framing is off.
	always_ff @(posedge clk) begin
		if (rst) begin
			free_frames <= 4'd0;
		end else if (rx_frame_start) begin
			free_frames <= free_frames + 4'd1;
		end
	end

	assign crc_mf_rx_flag = crc4_enable ? rx_crc_mf_start
		: rx_frame_start & (free_frames == `MF_FRAME_LAST);

	// Receive alarm events; levels re-set while the condition lasts.
	always_comb begin
		rx_alarm = 8'h00;
		rx_alarm[`B_SIG_ALL_ONES]  = sig_all_ones_flag;
		rx_alarm[`B_DISTANT_MF]    = distant_mf_alarm;
		rx_alarm[`B_SIG_ALL_ZEROS] = sig_all_zeros_flag;
		rx_alarm[`B_RX_SLIP]       = rx_estore_slip;
		rx_alarm[`B_UNFRAMED_ONES] = unframed_all_ones;
		rx_alarm[`B_FAR_END]       = far_end_alarm;
		rx_alarm[`B_CARRIER_LOSS]  = carrier_loss_flag;
		rx_alarm[`B_SYNC_LOSS]     = ~rx_in_sync;
	end

	// Timing events for the second status byte.
	always_comb begin
		events = 8'h00;
		events[`B_CAS_MF_RX]   = mf_start;
		events[`B_RX_ALIGN]    = align_rx;
		events[`B_TX_MF]       = tx_mf_start;
		events[`B_TIMER_TICK]  = timer_tick_flag;
		events[`B_TX_ALIGN]    = tx_align_start;
		events[`B_TX_CLK_LOSS] = tx_clock_loss_flag;
		events[`B_CRC_MF_RX]   = crc_mf_rx_flag;
		events[`B_TX_SLIP]     = tx_estore_slip;
	end

	// Port address decode.
	assign sel_alarm   = bus_addr == `REG_RX_ALARM_STATUS;
	assign sel_event   = bus_addr == `REG_EVENT_STATUS;
	assign sel_amask   = bus_addr == `REG_RX_ALARM_MASK;
	assign sel_emask   = bus_addr == `REG_EVENT_MASK;
	assign sel_summary = bus_addr == `REG_IRQ_SUMMARY;

	// Latch controls for both status bytes.
	assign alarm_if.set_ev  = rx_alarm;
	assign alarm_if.wr_stat = bus_wr & sel_alarm;
	assign alarm_if.wr_mask = bus_wr & sel_amask;
	assign alarm_if.wdata   = bus_wdata;
	assign event_if.set_ev  = events;
	assign event_if.wr_stat = bus_wr & sel_event;
	assign event_if.wr_mask = bus_wr & sel_emask;
	assign event_if.wdata   = bus_wdata;

	status_latch alarm_latch (
		.clk (clk),
		.rst (rst),
		.lif (alarm_if)
	);

	status_latch event_latch (
		.clk (clk),
		.rst (rst),
		.lif (event_if)
	);

	// Summary: own two bits at this framer's slot, peers elsewhere.
	assign framer_pending = {event_if.pending, alarm_if.pending};
	assign own_slot = 8'h03 << {FRAMER_INDEX, 1'b0};
	assign own_bits = {6'd0, framer_pending} << {FRAMER_INDEX, 1'b0};
	assign framer_irq_summary = (peer_irq_summary & ~own_slot)
		| own_bits;

	// Read data select; unmapped offsets read zero.
	assign next_rdata = sel_alarm ? alarm_if.rd_val
		: sel_event   ? event_if.rd_val
		: sel_amask   ? alarm_if.mask
		: sel_emask   ? event_if.mask
		: sel_summary ? framer_irq_summary
		: 8'h00;

	// Read data and shared interrupt come from flip-flops.
	always_ff @(posedge clk) begin
		if (rst) begin
			bus_rdata <= `RDATA_RESET;
			int_n <= 1'b1;
		end else begin
			if (bus_rd) begin
				bus_rdata <= next_rdata;
			end
			int_n <= ~|framer_irq_summary;
		end
	end
endmodule

// ===== dv/e1_alarm_chk.sv
// Purpose: Port-level checks on the alarm, event and interrupt block.
// Assumes: One clock with a synchronous active-high reset.
// Notes:   Bound to the block from the bench top file.
`timescale 1ns/100ps
module e1_alarm_chk (
	input wire logic                clk,
	input wire logic                rst,
	input wire logic [7:0]          bus_addr,
	input wire logic                bus_wr,
	input wire logic                bus_rd,
	input wire e1_alarm_pkg::byte_t bus_wdata,
	input wire e1_alarm_pkg::byte_t bus_rdata,
	input wire logic                line_tx_clock,
	input wire logic                clk_loss_pin_enable,
	input wire e1_alarm_pkg::byte_t peer_irq_summary,
	input wire logic [1:0]          framer_pending,
	input wire logic                tx_clock_loss_pin,
	input wire logic                int_n
);
	import e1_alarm_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// A mask write followed at once by a read of the same offset.
	sequence s_mask_wr;
		bus_wr && bus_addr == 8'h16;
	endsequence
	sequence s_mask_rd;
		bus_rd && !bus_wr && bus_addr == 8'h16;
	endsequence
	property p_mask_rb;
		s_mask_wr ##1 s_mask_rd |=> bus_rdata == $past(bus_wdata, 2);
	endproperty
	a_mask_rb: assert property (p_mask_rb)
		else $error("mask read-back differs from written byte");
	property p_hold;
		!bus_rd |=> $stable(bus_rdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved without a read");
	property p_unmap;
		bus_rd && bus_addr > 8'h18 |=> bus_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped offset read nonzero");
	property p_int_lo;
		framer_pending != 2'b00 |=> !int_n;
	endproperty
	a_int_lo: assert property (p_int_lo)
		else $error("interrupt not driven while pending");
	property p_int_hi;
		framer_pending == 2'b00 && peer_irq_summary[7:2] == 6'h00 |=> int_n;
	endproperty
	a_int_hi: assert property (p_int_hi)
		else $error("interrupt driven with nothing pending");
	property p_peer;
		peer_irq_summary[7:2] != 6'h00 |=> !int_n;
	endproperty
	a_peer: assert property (p_peer)
		else $error("other framer pending did not drive interrupt");
	property p_sum;
		bus_rd && bus_addr == 8'h18 |=> bus_rdata ==
			{$past(peer_irq_summary[7:2]), $past(framer_pending)};
	endproperty
	a_sum: assert property (p_sum)
		else $error("summary read does not match pending bits");
	property p_pin;
		tx_clock_loss_pin |-> $past(clk_loss_pin_enable);
	endproperty
	a_pin: assert property (p_pin)
		else $error("clock-loss pin high while disabled");
	property p_toggle;
		$changed(line_tx_clock) ##1 $changed(line_tx_clock)
			|-> ##[1:6] !tx_clock_loss_pin;
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("clock-loss pin stays high with clock running");
endmodule

// ===== dv/e1_line_model.sv
// Purpose: Behavioural receive line and transmit clock source.
// Assumes: One line bit every second clk, 256 bits to a frame.
// Notes:   Every bit carries the same fill, chosen by the bench.
`timescale 1ns/100ps
module e1_line_model (
	input wire logic  clk,
	input wire logic  rst,
	input wire logic  ones,
	input wire logic  tx_run,
	output logic       rx_bit_en,
	output logic       rx_pos_rail,
	output logic       rx_neg_rail,
	output logic       rx_frame_start,
	output logic [3:0] rx_frame_num,
	output logic [4:0] rx_ts,
	output logic [2:0] rx_bit_index,
	output logic       line_tx_clock
);
	logic [7:0] bit_pos;
	logic       mark_pol;
	// Positions follow the bit counter; rails carry noise between bits.
	assign rx_ts          = bit_pos[7:3];
	assign rx_bit_index   = bit_pos[2:0];
	assign rx_frame_start = rx_bit_en && bit_pos == 8'h00;
	assign rx_pos_rail    = rx_bit_en ? ones && !mark_pol : bit_pos[0];
	assign rx_neg_rail    = rx_bit_en ? ones && mark_pol : !bit_pos[0];
	// Steps bit and frame counts; marks alternate in polarity.
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_bit_en <= 1'b0;
			bit_pos <= 8'h00;
			rx_frame_num <= 4'h0;
			mark_pol <= 1'b0;
			line_tx_clock <= 1'b0;
		end else begin
			rx_bit_en <= !rx_bit_en;
			if (rx_bit_en) begin
				bit_pos <= bit_pos + 8'h01;
				if (bit_pos == 8'hff) rx_frame_num <= rx_frame_num + 4'h1;
				if (ones) mark_pol <= !mark_pol;
			end
			if (tx_run) line_tx_clock <= !line_tx_clock;
		end
	end
endmodule

// ===== dv/e1_alarm_status_irq_bench.sv
// Purpose: Self-checking bench for the alarm, event and interrupt block.
// Assumes: Timer counts shortened to 40 and 10 line bits.
// Notes:   Line fill switches from all zeros to all ones mid-run.
`timescale 1ns/100ps
module e1_alarm_status_irq_bench;
	import e1_alarm_pkg::*;
	typedef struct {logic [7:0] a; byte_t d; byte_t e;} row_t;
	logic clk, rst, bus_wr, bus_rd, ones, tx_run, rx_in_sync;
	logic rx_estore_slip, tx_estore_slip, tx_align_start, tx_mf_start;
	logic timer_rate_select, clk_loss_pin_enable, tx_clock_loss_pin, int_n;
	logic crc4_enable, rx_crc_mf_start;
	logic rx_bit_en, rx_pos_rail, rx_neg_rail, rx_frame_start, line_tx_clock;
	logic [3:0] rx_frame_num;
	logic [4:0] rx_ts;
	logic [2:0] rx_bit_index;
	logic [1:0] framer_pending;
	logic [7:0] bus_addr;
	byte_t      bus_wdata, bus_rdata, peer_irq_summary, got;
	int         bad_count, check_count;
	row_t rows[5] = '{'{8'h16, 8'hA5, 8'hA5}, '{8'h17, 8'h5A, 8'h5A},
		'{8'h20, 8'hFF, 8'h00}, '{8'h16, 8'h00, 8'h00}, '{8'h17, 8'h00, 8'h00}};
	e1_alarm_status_irq #(.TICK_SLOW_BITS(40), .TICK_FAST_BITS(10)) uut (
		.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.rx_bit_en(rx_bit_en), .rx_pos_rail(rx_pos_rail),
		.rx_neg_rail(rx_neg_rail), .rx_frame_start(rx_frame_start),
		.rx_frame_num(rx_frame_num), .rx_ts(rx_ts),
		.rx_bit_index(rx_bit_index), .rx_in_sync(rx_in_sync),
		.rx_crc_mf_start(rx_crc_mf_start), .crc4_enable(crc4_enable),
		.rx_estore_slip(rx_estore_slip), .tx_estore_slip(tx_estore_slip),
		.tx_align_start(tx_align_start), .tx_mf_start(tx_mf_start),
		.line_tx_clock(line_tx_clock), .timer_rate_select(timer_rate_select),
		.clk_loss_pin_enable(clk_loss_pin_enable),
		.peer_irq_summary(peer_irq_summary), .framer_pending(framer_pending),
		.tx_clock_loss_pin(tx_clock_loss_pin), .int_n(int_n));
	e1_line_model line (
		.clk(clk), .rst(rst), .ones(ones), .tx_run(tx_run),
		.rx_bit_en(rx_bit_en), .rx_pos_rail(rx_pos_rail),
		.rx_neg_rail(rx_neg_rail), .rx_frame_start(rx_frame_start),
		.rx_frame_num(rx_frame_num), .rx_ts(rx_ts),
		.rx_bit_index(rx_bit_index), .line_tx_clock(line_tx_clock));
	// Free-running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = !clk;
	end
	// One-cycle write strobe; called at a falling edge.
	task automatic wr(input logic [7:0] a, input byte_t d);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
	endtask
	// One-cycle read strobe; data is settled by the next falling edge.
	task automatic rd(input logic [7:0] a, output byte_t d);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge clk);
		bus_rd = 1'b0;
		d = bus_rdata;
	endtask
	// Write all ones to a status offset, then read what was sampled.
	task automatic poll(input logic [7:0] a, output byte_t d);
		wr(a, 8'hFF);
		rd(a, d);
	endtask
	task automatic chk8(input string n, input byte_t e, input byte_t g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Cuts a hang short well after the expected run length.
	initial begin
		#(60000 * 20);
		bad_count++;
		close_out();
	end
	// Main sequence: reset, register table, then line scenarios.
	initial begin
		{bus_wr, bus_rd, ones, tx_run, rx_estore_slip, tx_estore_slip} = '0;
		{tx_align_start, tx_mf_start, timer_rate_select} = '0;
		{crc4_enable, rx_crc_mf_start} = '0;
		clk_loss_pin_enable = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 8'h00;
		peer_irq_summary = 8'h00;
		rx_in_sync = 1'b1;
		rst = 1'b1;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		chk8("rdata_reset", 8'h00, bus_rdata);
		chk1("int_n_reset", 1'b1, int_n);
		chk1("pin_reset", 1'b0, tx_clock_loss_pin);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, got);
			chk8("reg_table", rows[i].e, got);
		end
		$display("test reset and registers done");
		repeat (16600) @(negedge clk);
		poll(8'h06, got);
		repeat (1024) @(negedge clk);
		poll(8'h06, got);
		chk8("zero_line", 8'h22, got);
		wr(8'h16, 8'h11);
		rx_in_sync = 1'b0;
		rx_estore_slip = 1'b1;
		@(negedge clk);
		rx_in_sync = 1'b1;
		rx_estore_slip = 1'b0;
		repeat (3) @(negedge clk);
		chk1("int_n_alarm", 1'b0, int_n);
		poll(8'h06, got);
		chk8("sync_slip", 8'h11, got & 8'h11);
		poll(8'h06, got);
		chk8("latched_clear", 8'h00, got & 8'h11);
		repeat (3) @(negedge clk);
		chk1("int_n_cleared", 1'b1, int_n);
		wr(8'h16, 8'h00);
		$display("test zero line done");
		ones = 1'b1;
		tx_run = 1'b1;
		timer_rate_select = 1'b1;
		repeat (20) @(negedge clk);
		poll(8'h07, got);
		{tx_align_start, tx_mf_start, tx_estore_slip} = 3'b111;
		@(negedge clk);
		{tx_align_start, tx_mf_start, tx_estore_slip} = 3'b000;
		repeat (24600) @(negedge clk);
		poll(8'h06, got);
		repeat (1024) @(negedge clk);
		poll(8'h06, got);
		chk8("ones_line", 8'hCC, got);
		poll(8'h07, got);
		chk8("events", 8'hFB, got);
		wr(8'h17, 8'h10);
		repeat (24) @(negedge clk);
		chk1("int_n_event", 1'b0, int_n);
		wr(8'h17, 8'h00);
		repeat (3) @(negedge clk);
		chk1("int_n_masked", 1'b1, int_n);
		$display("test ones line done");
		tx_run = 1'b0;
		clk_loss_pin_enable = 1'b1;
		repeat (40) @(negedge clk);
		chk1("loss_pin", 1'b1, tx_clock_loss_pin);
		poll(8'h07, got);
		chk8("tx_clock_loss", 8'h04, got & 8'h04);
		tx_run = 1'b1;
		peer_irq_summary = 8'h30;
		repeat (2) @(negedge clk);
		chk1("int_n_peer", 1'b0, int_n);
		rd(8'h18, got);
		chk8("summary", 8'h30, got);
		peer_irq_summary = 8'h00;
		$display("test clock loss and summary done");
		// Slow timer: no tick 70 cycles after one, then one by 80.
		timer_rate_select = 1'b0;
		wr(8'h17, 8'h10);
		poll(8'h07, got);
		@(negedge clk iff !int_n);
		poll(8'h07, got);
		repeat (70) @(negedge clk);
		chk1("slow_tick_quiet", 1'b1, int_n);
		repeat (10) @(negedge clk);
		chk1("slow_tick", 1'b0, int_n);
		wr(8'h17, 8'h00);
		// With CRC4 framing on, only its own boundary sets the flag.
		crc4_enable = 1'b1;
		poll(8'h07, got);
		poll(8'h07, got);
		chk8("crc_mf_quiet", 8'h00, got & 8'h02);
		rx_crc_mf_start = 1'b1;
		@(negedge clk);
		rx_crc_mf_start = 1'b0;
		poll(8'h07, got);
		chk8("crc_mf_on", 8'h02, got & 8'h02);
		// A zero line ends unframed ones and brings carrier loss back.
		ones = 1'b0;
		repeat (1100) @(negedge clk);
		poll(8'h06, got);
		repeat (1100) @(negedge clk);
		poll(8'h06, got);
		chk8("zeros_again", 8'h02, got & 8'h0A);
		$display("test timer, crc and unframed clear done");
		close_out();
	end
endmodule
bind e1_alarm_status_irq e1_alarm_chk u_chk (
	.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
	.line_tx_clock(line_tx_clock), .clk_loss_pin_enable(clk_loss_pin_enable),
	.peer_irq_summary(peer_irq_summary), .framer_pending(framer_pending),
	.tx_clock_loss_pin(tx_clock_loss_pin), .int_n(int_n));
